// [pkg/breakpoint_unit_params.svh]
// Offsets, field positions, codes and timing counts of the breakpoint unit
`ifndef BREAKPOINT_UNIT_PARAMS_SVH
`define BREAKPOINT_UNIT_PARAMS_SVH

`define BPU_OFS_A_ADDR   8'h00
`define BPU_OFS_A_ASID   8'h04
`define BPU_OFS_A_MASK   8'h08
`define BPU_OFS_A_CYC    8'h0C
`define BPU_OFS_B_ADDR   8'h10
`define BPU_OFS_B_ASID   8'h14
`define BPU_OFS_B_MASK   8'h18
`define BPU_OFS_B_DATA   8'h1C
`define BPU_OFS_B_DMASK  8'h20
`define BPU_OFS_B_CYC    8'h24
`define BPU_OFS_CTRL     8'h28

`define BPU_SZ_BYTE      2'h0
`define BPU_SZ_WORD      2'h1
`define BPU_SZ_LONG      2'h2

`define BPU_MASK_RW      8'h0F
`define BPU_CYC_RW       16'h007F
`define BPU_CTRL_RW      16'hC4C9

`define BPU_CTRL_CHAN_A_MATCH_FLAG    15
`define BPU_CTRL_CHAN_B_MATCH_FLAG    14
`define BPU_CTRL_PCBA    10
`define BPU_CTRL_CHAN_B_DATA_COMPARE_ENABLE    7
`define BPU_CTRL_PCBB    6
`define BPU_CTRL_SEQ     3
`define BPU_CTRL_UBDE    0

`define BPU_MASK_ASID    2
`define BPU_MASK_SEL2    3
`define BPU_MASK_SEL1    1
`define BPU_MASK_SEL0    0

`define BPU_AM_ALL       3'h0
`define BPU_AM_LOW10     3'h1
`define BPU_AM_LOW12     3'h2
`define BPU_AM_NONE      3'h3
`define BPU_AM_LOW16     3'h4
`define BPU_AM_LOW20     3'h5

`define BPU_CYC_ID_HI    5
`define BPU_CYC_ID_LO    4
`define BPU_CYC_RW_HI    3
`define BPU_CYC_RW_LO    2
`define BPU_CYC_SZ2      6
`define BPU_CYC_SZ1      1
`define BPU_CYC_SZ0      0

`define BPU_SETTLE_STATES 6
`define BPU_SETTLE_CYC    3'(`BPU_SETTLE_STATES)

`endif

// [pkg/breakpoint_unit_pkg.sv]
// Types of the breakpoint unit
package breakpoint_unit_pkg;

   typedef enum logic [1:0] {
      SEQ_IDLE   = 2'b01,
      SEQ_A_SEEN = 2'b10
   } seq_state_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [7:0]  asid;
      logic [7:0]  mask;
      logic [15:0] cyc;
   } chan_cfg_t;

   typedef struct packed {
      chan_cfg_t   a;
      chan_cfg_t   b;
      logic [31:0] data;
      logic [31:0] dmask;
      logic        pcba;
      logic        pcbb;
      logic        chan_b_data_compare_enable;
      logic        seq;
   } cmp_t;

   typedef struct packed {
      cmp_t prog;
      cmp_t act;
   } cfg_t;

   typedef struct packed {
      logic        cmf_a;
      logic        cmf_b;
      logic        ubde;
      seq_state_t  seq_state;
      logic [2:0]  settle_cnt;
      logic        post_pend;
      logic [31:0] rdata;
      logic        brk;
      logic        brk_post;
   } st_t;

endpackage : breakpoint_unit_pkg

// [hdl/chan_match.sv]
// Combinational match of one breakpoint channel against a CPU bus cycle
`timescale 1ns/1ps
`include "breakpoint_unit_params.svh"

module chan_match (
   input  wire logic [31:0] i_addr_cmp,
   input  wire logic [7:0]  i_asid_cmp,
   input  wire logic [7:0]  i_mask,
   input  wire logic [15:0] i_cyc,
   input  wire logic        i_data_en,
   input  wire logic [31:0] i_data_cmp,
   input  wire logic [31:0] i_data_mask,
   input  wire logic        i_valid,
   input  wire logic [31:0] i_addr,
   input  wire logic [7:0]  i_asid,
   input  wire logic [31:0] i_data,
   input  wire logic        i_instr,
   input  wire logic        i_write,
   input  wire logic [1:0]  i_size,
   output logic             o_hit
);

   logic [31:0] amask;
   logic [2:0]  sel;
   logic [1:0]  id_sel;
   logic [1:0]  rw_sel;
   logic [2:0]  sz_sel;
   logic        addr_ok;
   logic        asid_ok;
   logic        kind_ok;
   logic        dir_ok;
   logic        size_ok;
   logic        data_ok;

   always_comb begin
      sel    = {i_mask[`BPU_MASK_SEL2], i_mask[`BPU_MASK_SEL1],
                i_mask[`BPU_MASK_SEL0]};
      id_sel = {i_cyc[`BPU_CYC_ID_HI], i_cyc[`BPU_CYC_ID_LO]};
      rw_sel = {i_cyc[`BPU_CYC_RW_HI], i_cyc[`BPU_CYC_RW_LO]};
      sz_sel = {i_cyc[`BPU_CYC_SZ2], i_cyc[`BPU_CYC_SZ1],
                i_cyc[`BPU_CYC_SZ0]};
      case (sel)
         `BPU_AM_LOW10: amask = 32'hFFFF_FC00;
         `BPU_AM_LOW12: amask = 32'hFFFF_F000;
         `BPU_AM_LOW16: amask = 32'hFFFF_0000;
         `BPU_AM_LOW20: amask = 32'hFFF0_0000;
         `BPU_AM_NONE:  amask = 32'h0000_0000;
         default:       amask = 32'hFFFF_FFFF;
      endcase
      addr_ok = ((i_addr ^ i_addr_cmp) & amask) == 32'h0000_0000;
      asid_ok = i_mask[`BPU_MASK_ASID] ||
                (i_asid == i_asid_cmp);
      // Code 00 switches the channel off
      kind_ok = i_instr ? id_sel[0] : id_sel[1];
      dir_ok  = (rw_sel == 2'h0) ||
                (i_write ? rw_sel[1] : rw_sel[0]);
      // Size code 1..4 stands for byte..quadword, 0 for any size
      size_ok = (sz_sel == 3'h0) ||
                (sz_sel == {1'b0, i_size} + 3'h1);
      data_ok = !i_data_en ||
                (((i_data ^ i_data_cmp) & ~i_data_mask) ==
                 32'h0000_0000);
      o_hit   = i_valid && addr_ok && asid_ok && kind_ok && dir_ok &&
                size_ok && data_ok;
   end

endmodule : chan_match

// [hdl/breakpoint_unit.sv]
// Two-channel breakpoint unit: compare registers, match and break logic
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "breakpoint_unit_params.svh"

module breakpoint_unit (
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [31:0] i_reg_wdata,
   input  wire logic [1:0]  i_reg_size,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic        i_cyc_valid,
   input  wire logic [31:0] i_cyc_addr,
   input  wire logic [7:0]  i_cyc_asid,
   input  wire logic [31:0] i_cyc_data,
   input  wire logic        i_cyc_instr,
   input  wire logic        i_cyc_write,
   input  wire logic [1:0]  i_cyc_size,
   input  wire logic        i_insn_done,
   input  wire logic        i_rte,
   output logic [31:0]      o_reg_rdata,
   output logic             o_break,
   output logic             o_break_post,
   output logic             o_debug_enable
);

   // Two copies: prog is what software sees, act what the matchers use
   breakpoint_unit_pkg::cfg_t cfg_reg;
   breakpoint_unit_pkg::cfg_t cfg_next;
   breakpoint_unit_pkg::st_t  st_reg;
   breakpoint_unit_pkg::st_t  st_next;

   logic        hit_a;
   logic        hit_b;
   logic        wr_ok;
   logic        rd_ok;
   logic [1:0]  need_size;
   logic [31:0] rd_val;
   logic [15:0] ctrl_val;
   logic [15:0] wctrl;
   logic        ev_a;
   logic        ev_b;
   logic        fire;
   logic        fire_instr;
   logic        fire_post;
   logic        ctrl_wr;
   logic        settle_done;
   logic [1:0]  data_en;
   logic [1:0]  chan_hit;
   logic [31:0] data_cmp  [2];
   logic [31:0] data_mask [2];
   breakpoint_unit_pkg::chan_cfg_t chan_cfg [2];

   // Channel A has no data compare: its data mask ignores every bit
   always_comb begin
      chan_cfg[0]  = cfg_reg.act.a;
      chan_cfg[1]  = cfg_reg.act.b;
      data_en[0]   = 1'b0;
      data_en[1]   = cfg_reg.act.chan_b_data_compare_enable;
      data_cmp[0]  = 32'h0000_0000;
      data_cmp[1]  = cfg_reg.act.data;
      data_mask[0] = 32'hFFFF_FFFF;
      data_mask[1] = cfg_reg.act.dmask;
   end

   // One matcher per channel, both watching the same CPU bus cycle
   for (genvar c = 0; c < 2; c++) begin : g_chan
      chan_match u_chan (
         .i_addr_cmp  (chan_cfg[c].addr),
         .i_asid_cmp  (chan_cfg[c].asid),
         .i_mask      (chan_cfg[c].mask),
         .i_cyc       (chan_cfg[c].cyc),
         .i_data_en   (data_en[c]),
         .i_data_cmp  (data_cmp[c]),
         .i_data_mask (data_mask[c]),
         .i_valid     (i_cyc_valid),
         .i_addr      (i_cyc_addr),
         .i_asid      (i_cyc_asid),
         .i_data      (i_cyc_data),
         .i_instr     (i_cyc_instr),
         .i_write     (i_cyc_write),
         .i_size      (i_cyc_size),
         .o_hit       (chan_hit[c])
      );
   end

   assign hit_a = chan_hit[0];
   assign hit_b = chan_hit[1];

   // Width of the addressed register sets the only legal access size
   always_comb begin
      case (i_reg_addr)
         `BPU_OFS_A_ASID, `BPU_OFS_A_MASK,
         `BPU_OFS_B_ASID, `BPU_OFS_B_MASK: need_size = `BPU_SZ_BYTE;
         `BPU_OFS_A_CYC, `BPU_OFS_B_CYC,
         `BPU_OFS_CTRL:                    need_size = `BPU_SZ_WORD;
         default:                          need_size = `BPU_SZ_LONG;
      endcase
      wr_ok = i_reg_wr && (i_reg_size == need_size);
      rd_ok = i_reg_rd && (i_reg_size == need_size);
      ctrl_wr     = wr_ok && (i_reg_addr == `BPU_OFS_CTRL);
      settle_done = (st_reg.settle_cnt == 3'h1);
   end

   // Control word as software sees it; reserved bits read zero
   always_comb begin
      ctrl_val = 16'h0000;
      ctrl_val[`BPU_CTRL_CHAN_A_MATCH_FLAG] = st_reg.cmf_a;
      ctrl_val[`BPU_CTRL_CHAN_B_MATCH_FLAG] = st_reg.cmf_b;
      ctrl_val[`BPU_CTRL_PCBA] = cfg_reg.prog.pcba;
      ctrl_val[`BPU_CTRL_CHAN_B_DATA_COMPARE_ENABLE] = cfg_reg.prog.chan_b_data_compare_enable;
      ctrl_val[`BPU_CTRL_PCBB] = cfg_reg.prog.pcbb;
      ctrl_val[`BPU_CTRL_SEQ]  = cfg_reg.prog.seq;
      ctrl_val[`BPU_CTRL_UBDE] = st_reg.ubde;
      // Read mux; unmapped offsets read zero
      case (i_reg_addr)
         `BPU_OFS_A_ADDR:  rd_val = cfg_reg.prog.a.addr;
         `BPU_OFS_A_ASID:  rd_val = {24'h00_0000,
                                     cfg_reg.prog.a.asid};
         `BPU_OFS_A_MASK:  rd_val = {24'h00_0000, cfg_reg.prog.a.mask &
                                     `BPU_MASK_RW};
         `BPU_OFS_A_CYC:   rd_val = {16'h0000, cfg_reg.prog.a.cyc};
         `BPU_OFS_B_ADDR:  rd_val = cfg_reg.prog.b.addr;
         `BPU_OFS_B_ASID:  rd_val = {24'h00_0000, cfg_reg.prog.b.asid};
         `BPU_OFS_B_MASK:  rd_val = {24'h00_0000, cfg_reg.prog.b.mask &
                                     `BPU_MASK_RW};
         `BPU_OFS_B_DATA:  rd_val = cfg_reg.prog.data;
         `BPU_OFS_B_DMASK: rd_val = cfg_reg.prog.dmask;
         `BPU_OFS_B_CYC:   rd_val = {16'h0000, cfg_reg.prog.b.cyc};
         `BPU_OFS_CTRL:    rd_val = {16'h0000, ctrl_val};
         default:          rd_val = 32'h0000_0000;
      endcase
   end

   // Compare registers: software copy and the copy the matchers use
   always_comb begin
      cfg_next = cfg_reg;
      wctrl    = i_reg_wdata[15:0];
      if (wr_ok) begin
         case (i_reg_addr)
            `BPU_OFS_A_ADDR:  cfg_next.prog.a.addr = i_reg_wdata;
            `BPU_OFS_A_ASID:  cfg_next.prog.a.asid =
                                 i_reg_wdata[7:0];
            `BPU_OFS_A_MASK:  cfg_next.prog.a.mask =
                                 i_reg_wdata[7:0] & `BPU_MASK_RW;
            `BPU_OFS_A_CYC:   cfg_next.prog.a.cyc =
                                 wctrl & `BPU_CYC_RW;
            `BPU_OFS_B_ADDR:  cfg_next.prog.b.addr = i_reg_wdata;
            `BPU_OFS_B_ASID:  cfg_next.prog.b.asid = i_reg_wdata[7:0];
            `BPU_OFS_B_MASK:  cfg_next.prog.b.mask =
                                 i_reg_wdata[7:0] & `BPU_MASK_RW;
            `BPU_OFS_B_DATA:  cfg_next.prog.data = i_reg_wdata;
            `BPU_OFS_B_DMASK: cfg_next.prog.dmask = i_reg_wdata;
            `BPU_OFS_B_CYC:   cfg_next.prog.b.cyc =
                                 wctrl & `BPU_CYC_RW;
            `BPU_OFS_CTRL: begin
               // Match flags are state, handled with the sequencer below
               cfg_next.prog.pcba = wctrl[`BPU_CTRL_PCBA];
               cfg_next.prog.pcbb = wctrl[`BPU_CTRL_PCBB];
               cfg_next.prog.chan_b_data_compare_enable = wctrl[`BPU_CTRL_CHAN_B_DATA_COMPARE_ENABLE];
               cfg_next.prog.seq  = wctrl[`BPU_CTRL_SEQ];
            end
            default: cfg_next.prog = cfg_reg.prog;
         endcase
      end
      // Matchers pick up new values on a return or once settled
      if (i_rte || settle_done) begin
         cfg_next.act = cfg_reg.prog;
      end
   end

   // Compare registers keep their contents through reset
   always_ff @(posedge i_clk) begin
      cfg_reg <= cfg_next;
   end

   // Break decision
   always_comb begin
      ev_a       = hit_a;
      ev_b       = hit_b;
      fire       = 1'b0;
      fire_instr = 1'b0;
      fire_post  = 1'b0;
      if (cfg_reg.act.seq) begin
         // Channel B counts only once channel A has been seen
         ev_b = hit_b &&
                (st_reg.seq_state == breakpoint_unit_pkg::SEQ_A_SEEN);
         fire = ev_b;
         fire_post = cfg_reg.act.pcbb;
      end else begin
         fire = hit_a || hit_b;
         fire_post = hit_b ? cfg_reg.act.pcbb : cfg_reg.act.pcba;
      end
      fire_instr = fire && i_cyc_instr;
   end

   // Flags, sequencer, settle count and break pulses
   always_comb begin
      st_next          = st_reg;
      st_next.brk      = 1'b0;
      st_next.brk_post = 1'b0;
      // Read data stands for one cycle only, zero otherwise
      st_next.rdata    = 32'h0000_0000;
      if (rd_ok) begin
         st_next.rdata = rd_val;
      end
      // A write restarts the settle count; a return loads at once
      if (wr_ok) begin
         st_next.settle_cnt = `BPU_SETTLE_CYC;
      end else if (i_rte) begin
         st_next.settle_cnt = 3'h0;
      end else if (st_reg.settle_cnt != 3'h0) begin
         st_next.settle_cnt = st_reg.settle_cnt - 3'h1;
      end
      // Software writes zero to clear a flag; a match wins the clear
      if (ctrl_wr) begin
         st_next.cmf_a = st_reg.cmf_a & wctrl[`BPU_CTRL_CHAN_A_MATCH_FLAG];
         st_next.cmf_b = st_reg.cmf_b & wctrl[`BPU_CTRL_CHAN_B_MATCH_FLAG];
         st_next.ubde  = wctrl[`BPU_CTRL_UBDE];
      end
      if (ev_a) begin
         st_next.cmf_a = 1'b1;
      end
      if (ev_b) begin
         st_next.cmf_b = 1'b1;
      end
      // Sequencer: an A hit arms, a later B hit breaks and disarms
      case (st_reg.seq_state)
         breakpoint_unit_pkg::SEQ_IDLE: begin
            if (cfg_reg.act.seq && hit_a) begin
               st_next.seq_state = breakpoint_unit_pkg::SEQ_A_SEEN;
            end
         end
         breakpoint_unit_pkg::SEQ_A_SEEN: begin
            if (!cfg_reg.act.seq || ev_b) begin
               st_next.seq_state = breakpoint_unit_pkg::SEQ_IDLE;
            end
         end
         default: st_next.seq_state = breakpoint_unit_pkg::SEQ_IDLE;
      endcase
      // Post-execution instruction breaks wait for the retire pulse
      if (st_reg.post_pend && i_insn_done) begin
         st_next.post_pend = 1'b0;
         st_next.brk       = 1'b1;
         st_next.brk_post  = 1'b1;
      end
      // Operand and before-execution breaks leave on the next edge
      if (fire) begin
         if (fire_instr && fire_post) begin
            st_next.post_pend = 1'b1;
         end else begin
            st_next.brk = 1'b1;
         end
      end
   end

   // Flags and break state clear on reset; compare registers do not
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_reg <= '{cmf_a:      1'b0,
                     cmf_b:      1'b0,
                     ubde:       1'b0,
                     seq_state:  breakpoint_unit_pkg::SEQ_IDLE,
                     settle_cnt: 3'h0,
                     post_pend:  1'b0,
                     rdata:      32'h0000_0000,
                     brk:        1'b0,
                     brk_post:   1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   // Every output comes straight from a register
   assign o_reg_rdata    = st_reg.rdata;
   assign o_break        = st_reg.brk;
   assign o_break_post   = st_reg.brk_post;
   assign o_debug_enable = st_reg.ubde;

endmodule : breakpoint_unit

// [tb/breakpoint_unit_props.sv]
// Checker of the breakpoint unit's port behaviour
`timescale 1ns/1ps
`include "breakpoint_unit_params.svh"

module breakpoint_unit_props (
   input wire logic        i_clk,
   input wire logic        i_rstn,
   input wire logic [7:0]  i_reg_addr,
   input wire logic [1:0]  i_reg_size,
   input wire logic        i_reg_rd,
   input wire logic        i_cyc_valid,
   input wire logic        i_insn_done,
   input wire logic [31:0] o_reg_rdata,
   input wire logic        o_break,
   input wire logic        o_break_post
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   AST_RDATA_IDLE: assert property (!$past(i_reg_rd) |->
      o_reg_rdata == 32'h0000_0000)
      else $error("read data not idle");
   AST_POST_WITH_BREAK: assert property (o_break_post |-> o_break)
      else $error("post break without break");
   AST_BREAK_CAUSE: assert property (o_break |->
      $past(i_cyc_valid) || $past(i_insn_done))
      else $error("break without bus cycle");
   AST_POST_CAUSE: assert property (o_break_post |->
      $past(i_insn_done))
      else $error("post break without finished instruction");
   AST_MASK_TOP_ZERO: assert property (i_reg_rd &&
      i_reg_addr == `BPU_OFS_A_MASK |-> ##1 o_reg_rdata[31:4] == 28'h000_0000)
      else $error("mask upper bits not zero");
   AST_ASID_WIDTH: assert property (i_reg_rd &&
      i_reg_addr == `BPU_OFS_A_ASID |-> ##1 o_reg_rdata[31:8] == 24'h00_0000)
      else $error("space id wider than eight bits");
   AST_WRONG_SIZE: assert property (i_reg_rd &&
      i_reg_addr == `BPU_OFS_A_ADDR && i_reg_size != 2'h2
      |-> ##1 o_reg_rdata == 32'h0000_0000)
      else $error("wrong size read gave data");
   AST_CTRL_RSVD: assert property (i_reg_rd &&
      i_reg_addr == `BPU_OFS_CTRL |-> ##1
      (o_reg_rdata & ~32'h0000_C4C9) == 32'h0000_0000)
      else $error("control reserved bits not zero");
endmodule : breakpoint_unit_props

// [tb/cpu_bus_model.sv]
// Behavioural CPU core issuing bus cycles to the breakpoint unit
`timescale 1ns/1ps

module cpu_bus_model (
   input  wire logic        i_clk,
   output logic             o_valid,
   output logic [31:0]      o_addr,
   output logic [7:0]       o_asid,
   output logic [31:0]      o_data,
   output logic             o_instr,
   output logic             o_write,
   output logic [1:0]       o_size,
   output logic             o_insn_done,
   output logic             o_rte
);
   initial begin
      {o_valid, o_instr, o_write, o_insn_done, o_rte} = 5'h00;
      {o_addr, o_data} = 64'h0000_0000_0000_0000;
      o_asid = 8'h00;
      o_size = 2'h0;
   end

   task automatic issue(input logic [31:0] a, input logic [7:0] s,
                        input logic [31:0] d, input logic ins,
                        input logic w, input logic [1:0] z);
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_addr  <= a;
      o_asid  <= s;
      o_data  <= d;
      o_instr <= ins;
      o_write <= w;
      o_size  <= z;
      @(posedge i_clk);
      o_valid <= 1'b0;
      // Stale values are scrambled so that a late sample cannot match
      o_addr  <= ~a;
      o_asid  <= ~s;
      o_data  <= ~d;
   endtask : issue

   task automatic pulse(input logic ret);
      @(posedge i_clk);
      if (ret) o_rte <= 1'b1;
      else o_insn_done <= 1'b1;
      @(posedge i_clk);
      {o_rte, o_insn_done} <= 2'h0;
   endtask : pulse
endmodule : cpu_bus_model

// [tb/breakpoint_unit_tb.sv]
// Self-checking testbench of the breakpoint unit
`timescale 1ns/1ps
`include "breakpoint_unit_params.svh"

module breakpoint_unit_tb;
   typedef struct packed {
      logic [7:0]  m;
      logic [31:0] a;
      logic [7:0]  s;
      logic        e;
   } row_t;
   logic        i_clk, i_rstn, i_reg_wr, i_reg_rd;
   logic [7:0]  i_reg_addr;
   logic [31:0] i_reg_wdata;
   logic [1:0]  i_reg_size;
   logic        cyc_valid, cyc_instr, cyc_write, insn_done, rte;
   logic [31:0] cyc_addr, cyc_data, o_reg_rdata;
   logic [7:0]  cyc_asid;
   logic [1:0]  cyc_size;
   logic        o_break, o_break_post, o_debug_enable;
   int          fails = 0;
   int          compares = 0;
   row_t rows [13] = '{
      '{8'h00, 32'h1234_5678, 8'h5A, 1'b1},
      '{8'h00, 32'h1234_5679, 8'h5A, 1'b0},
      '{8'h00, 32'h1234_5678, 8'h5B, 1'b0},
      '{8'h04, 32'h1234_5678, 8'hA5, 1'b1},
      '{8'h01, 32'h1234_5400, 8'h5A, 1'b1},
      '{8'h01, 32'h1234_5278, 8'h5A, 1'b0},
      '{8'h02, 32'h1234_5000, 8'h5A, 1'b1},
      '{8'h02, 32'h1234_4678, 8'h5A, 1'b0},
      '{8'h08, 32'h1234_0000, 8'h5A, 1'b1},
      '{8'h08, 32'h1235_5678, 8'h5A, 1'b0},
      '{8'h09, 32'h1230_0000, 8'h5A, 1'b1},
      '{8'h09, 32'h1224_5678, 8'h5A, 1'b0},
      '{8'h03, 32'hFFFF_FFFF, 8'h5A, 1'b1}};

   breakpoint_unit breakpoint_unit_i (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_reg_size(i_reg_size),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_cyc_valid(cyc_valid),
      .i_cyc_addr(cyc_addr), .i_cyc_asid(cyc_asid), .i_cyc_data(cyc_data),
      .i_cyc_instr(cyc_instr), .i_cyc_write(cyc_write),
      .i_cyc_size(cyc_size), .i_insn_done(insn_done), .i_rte(rte),
      .o_reg_rdata(o_reg_rdata), .o_break(o_break),
      .o_break_post(o_break_post), .o_debug_enable(o_debug_enable));
   cpu_bus_model cpu_bus_model_i (
      .i_clk(i_clk), .o_valid(cyc_valid), .o_addr(cyc_addr),
      .o_asid(cyc_asid), .o_data(cyc_data), .o_instr(cyc_instr),
      .o_write(cyc_write), .o_size(cyc_size), .o_insn_done(insn_done),
      .o_rte(rte));

   task automatic check(input string n, input logic [31:0] seen,
                        input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] z);
      @(posedge i_clk);
      i_reg_wr    <= 1'b1;
      i_reg_addr  <= a;
      i_reg_wdata <= d;
      i_reg_size  <= z;
      @(posedge i_clk);
      i_reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [1:0] z,
                     input logic [31:0] exp);
      @(posedge i_clk);
      i_reg_rd   <= 1'b1;
      i_reg_addr <= a;
      i_reg_size <= z;
      @(posedge i_clk);
      i_reg_rd   <= 1'b0;
      #1 check("read data", o_reg_rdata, exp);
   endtask : rd

   task automatic hit(input logic [31:0] a, input logic ins, input logic w,
                      input logic [1:0] z, input logic e,
                      input logic [7:0] s = 8'h5A,
                      input logic [31:0] d = 32'h0000_0000);
      cpu_bus_model_i.issue(a, s, d, ins, w, z);
      #1 check("break", 32'(o_break), 32'(e));
   endtask : hit

   task automatic end_of_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   initial begin
      #40000;
      fails++;
      end_of_test();
   end

   initial begin
      {i_rstn, i_reg_wr, i_reg_rd, i_reg_size} = 5'h00;
      i_reg_addr = 8'h00;
      i_reg_wdata = 32'h0000_0000;
      repeat (10) @(posedge i_clk);
      i_rstn <= 1'b1;
      #1 check("break at reset", 32'(o_break), 32'h0000_0000);
      wr(`BPU_OFS_CTRL, 32'h0000_0000, 2'h1);
      wr(`BPU_OFS_B_CYC, 32'h0000_0000, 2'h1);
      wr(`BPU_OFS_A_ADDR, 32'h1234_5678, 2'h2);
      wr(`BPU_OFS_A_ASID, 32'h0000_005A, 2'h0);
      wr(`BPU_OFS_A_CYC, 32'h0000_0030, 2'h1);
      foreach (rows[i]) begin
         wr(`BPU_OFS_A_MASK, 32'(rows[i].m), 2'h0);
         repeat (8) @(posedge i_clk);
         hit(rows[i].a, 1'b0, 1'b0, 2'h2, rows[i].e, rows[i].s);
      end
      // Readback, reserved bits and refused sizes
      rd(`BPU_OFS_A_ADDR, 2'h2, 32'h1234_5678);
      rd(`BPU_OFS_A_ASID, 2'h0, 32'h0000_005A);
      wr(`BPU_OFS_A_MASK, 32'h0000_00FF, 2'h0);
      rd(`BPU_OFS_A_MASK, 2'h0, 32'h0000_000F);
      wr(`BPU_OFS_A_ADDR, 32'hDEAD_BEEF, 2'h1);
      rd(`BPU_OFS_A_ADDR, 2'h2, 32'h1234_5678);
      rd(`BPU_OFS_A_ADDR, 2'h1, 32'h0000_0000);
      rd(8'h3C, 2'h2, 32'h0000_0000);
      wr(`BPU_OFS_A_MASK, 32'h0000_0000, 2'h0);
      wr(`BPU_OFS_CTRL, 32'h0000_0000, 2'h1);
      repeat (8) @(posedge i_clk);
      hit(32'h1234_5678, 1'b0, 1'b0, 2'h2, 1'b1);
      hit(32'h0000_0000, 1'b0, 1'b0, 2'h2, 1'b0);
      rd(`BPU_OFS_CTRL, 2'h1, 32'h0000_8000);
      wr(`BPU_OFS_CTRL, 32'h0000_0000, 2'h1);
      rd(`BPU_OFS_CTRL, 2'h1, 32'h0000_0000);
      // New values act only after the settle time or a return
      wr(`BPU_OFS_A_ADDR, 32'h0000_4000, 2'h2);
      hit(32'h0000_4000, 1'b0, 1'b0, 2'h2, 1'b0);
      repeat (4) @(posedge i_clk);
      hit(32'h0000_4000, 1'b0, 1'b0, 2'h2, 1'b1);
      wr(`BPU_OFS_A_ADDR, 32'h0000_8000, 2'h2);
      cpu_bus_model_i.pulse(1'b1);
      hit(32'h0000_8000, 1'b0, 1'b0, 2'h2, 1'b1);
      // Operand size codes 1 to 4, then kind and direction
      for (int k = 0; k < 4; k++) begin
         wr(`BPU_OFS_A_CYC, (k == 3) ? 32'h0000_0070 : 32'(k + 49), 2'h1);
         repeat (8) @(posedge i_clk);
         hit(32'h0000_8000, 1'b0, 1'b0, 2'(k), 1'b1);
         hit(32'h0000_8000, 1'b0, 1'b0, 2'(k + 1), 1'b0);
      end
      wr(`BPU_OFS_A_CYC, 32'h0000_0028, 2'h1);
      repeat (8) @(posedge i_clk);
      hit(32'h0000_8000, 1'b0, 1'b1, 2'h2, 1'b1);
      hit(32'h0000_8000, 1'b0, 1'b0, 2'h2, 1'b0);
      hit(32'h0000_8000, 1'b1, 1'b1, 2'h2, 1'b0);
      // Instruction break taken after execution
      wr(`BPU_OFS_CTRL, 32'h0000_0401, 2'h1);
      wr(`BPU_OFS_A_CYC, 32'h0000_0010, 2'h1);
      repeat (8) @(posedge i_clk);
      hit(32'h0000_8000, 1'b1, 1'b0, 2'h2, 1'b0);
      cpu_bus_model_i.pulse(1'b0);
      #1 check("break post", 32'(o_break_post), 32'h0000_0001);
      check("debug enable", 32'(o_debug_enable), 32'h0000_0001);
      // Sequential A then B, then channel B data compare
      wr(`BPU_OFS_B_ADDR, 32'h0000_2000, 2'h2);
      wr(`BPU_OFS_B_MASK, 32'h0000_0004, 2'h0);
      wr(`BPU_OFS_B_CYC, 32'h0000_0030, 2'h1);
      wr(`BPU_OFS_A_CYC, 32'h0000_0030, 2'h1);
      wr(`BPU_OFS_CTRL, 32'h0000_0008, 2'h1);
      repeat (8) @(posedge i_clk);
      hit(32'h0000_2000, 1'b0, 1'b0, 2'h2, 1'b0);
      hit(32'h0000_8000, 1'b0, 1'b0, 2'h2, 1'b0);
      hit(32'h0000_2000, 1'b0, 1'b0, 2'h2, 1'b1);
      wr(`BPU_OFS_B_DATA, 32'hCAFE_0001, 2'h2);
      wr(`BPU_OFS_B_DMASK, 32'h0000_00FF, 2'h2);
      wr(`BPU_OFS_CTRL, 32'h0000_0080, 2'h1);
      repeat (8) @(posedge i_clk);
      hit(32'h0000_2000, 1'b0, 1'b1, 2'h2, 1'b1,
          8'h00, 32'hCAFE_00AA);
      hit(32'h0000_2000, 1'b0, 1'b1, 2'h2, 1'b0,
          8'h00, 32'hCAFF_0001);
      // A reset in mid-run clears the flags and keeps the compare values
      @(posedge i_clk);
      i_rstn <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rstn <= 1'b1;
      rd(`BPU_OFS_A_ADDR, 2'h2, 32'h0000_8000);
      rd(`BPU_OFS_A_ASID, 2'h0, 32'h0000_005A);
      rd(`BPU_OFS_CTRL, 2'h1, 32'h0000_0080);
      hit(32'h0000_2000, 1'b0, 1'b1, 2'h2, 1'b1,
          8'h00, 32'hCAFE_0001);
      end_of_test();
   end
endmodule : breakpoint_unit_tb

bind breakpoint_unit breakpoint_unit_props breakpoint_unit_props_i (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr),
   .i_reg_size(i_reg_size), .i_reg_rd(i_reg_rd),
   .i_cyc_valid(i_cyc_valid), .i_insn_done(i_insn_done),
   .o_reg_rdata(o_reg_rdata), .o_break(o_break),
   .o_break_post(o_break_post));
